// *** logic/i2c_addr_master.sv ***
// Two-wire bus block: slave address recognition, master addressing and master control.
// Assumes open-drain pads outside and a register master on the same clock.
//
// What this block does
// - Slave matches first byte against four identifiers.
// - Identifier bit 0 ignored in seven-bit matching.
// - Ten-bit enable gives one ten-bit slave address.
// - Ten-bit identifier layout with 11110b prefix.
// - Seven-bit target and direction in low target.
// - Ten-bit target split over both target registers.
// - Stop condition raises enabled completion interrupt.
// - Received not-acknowledge raises enabled interrupt.
// - Lost arbitration raises enabled interrupt.
// - Each acknowledged sent byte raises enabled interrupt.
// - Receive enable gates received-data interrupt.
// - Loopback routes own drives to own inputs.
// - Back-off disable lets master start anyway.
// - Otherwise master waits for a free bus.
// - Master enable bit switches master operation.
// - Control register 16 bits, resets to zero.
// - Status register 16 bits, read-only, resets zero.
// - Master or slave, never both together.
// - Never stretch the clock, tolerate others.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps

module i2c_addr_master
	import i2c_ctl_pkg::*;
#(
	parameter int HALF_CYCLES = HALF_CYC
) (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_i,
	// Register port.
	input wire reg_req_t req_i,
	output logic [15:0] rdata_o,
	// Bus pins.
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Interrupt request.
	output logic irq_o
);

	localparam int CW = $clog2(HALF_CYCLES + 1);

	function automatic logic id7_hit(input logic [7:0] id, input logic [7:0] b);
		return id[7:1] == b[7:1];
	endfunction : id7_hit

	mctl_t mctl_q;
	logic [7:0] id_q [4];
	logic [7:0] tlo_q, thi_q, txd_q, rxd_q, rx_d;
	logic [1:0] sctl_q;
	logic txv_q, busy_q, irq_q;
	logic [5:0] ev_q, ev_set;
	logic [15:0] rdata_q, rd_w, sta_w;
	logic scl_s1, scl_s2, sda_s1, sda_s2;
	logic scl_p_q, sda_p_q, scl_oe_q, sda_oe_q;
	mst_t st_q, st_d;
	logic [CW-1:0] cnt_q;
	logic [3:0] bit_q, bit_d;
	logic [1:0] ph_q, ph_d;
	logic [7:0] sh_q, sh_d;
	logic rd_q, rd_d;
	logic [3:0] s_cnt_q;
	logic [7:0] s_sh_q;
	logic s_on_q, s_byte_q, s_ack_q, s_addr_q, s_pre_q;

	// Register decode.
	wire men = mctl_q.master_enable;
	wire loop = mctl_q.internal_loopback_enable;
	wire [31:0] id_rel = req_i.addr - OFF_ID0;
	wire is_id = (id_rel < ID_SPAN) && (id_rel[1:0] == 2'h0);
	wire [1:0] id_ix = id_rel[3:2];
	wire wr_mctl = req_i.we && (req_i.addr == OFF_MCTL);
	wire wr_tlo = req_i.we && (req_i.addr == OFF_TLO);
	wire wr_thi = req_i.we && (req_i.addr == OFF_THI);
	wire wr_sctl = req_i.we && (req_i.addr == OFF_SCTL);
	wire wr_txd = req_i.we && (req_i.addr == OFF_TXD);
	wire rd_sta = req_i.re && (req_i.addr == OFF_MSTA);

	// Bus lines as seen by the engines.
	wire scl_l = loop ? !scl_oe_q : scl_s2;
	wire sda_l = loop ? !sda_oe_q : sda_s2;
	wire start_w = scl_l && scl_p_q && sda_p_q && !sda_l;
	wire stop_w = scl_l && scl_p_q && !sda_p_q && sda_l;
	wire scl_rise = scl_l && !scl_p_q;
	wire scl_fall = !scl_l && scl_p_q;

	// Master addressing.
	wire ten_m = tlo_q[7:3] == TEN_PREFIX;
	wire tick = cnt_q == CW'(HALF_CYCLES - 1);
	wire go_w = txv_q && men && (mctl_q.backoff_disable || !busy_q);
	wire snd_low = !rd_q && (bit_q < 4'h8) && !sh_q[7];
	wire msda_w = (st_q == M_START) || (st_q == M_STOP_A) || (st_q == M_STOP_B)
		|| (((st_q == M_LOW) || (st_q == M_HIGH)) && snd_low);
	wire mscl_d = (st_d == M_LOW) || (st_d == M_STOP_A);
	wire arb_w = !rd_q && (bit_q < 4'h8) && sh_q[7] && !sda_l;

	// Slave recognition.
	wire sen = sctl_q[SCTL_EN] && !men;
	wire ten_s = sctl_q[SCTL_TEN];
	wire hit7 = id7_hit(id_q[0], s_sh_q) || id7_hit(id_q[1], s_sh_q)
		|| id7_hit(id_q[2], s_sh_q) || id7_hit(id_q[3], s_sh_q);
	wire pre_hit = s_sh_q[7:1] == {TEN_PREFIX, id_q[1][2:1]};
	wire low_hit = s_sh_q == {id_q[1][0], id_q[0][7:1]};
	wire s_cmp = scl_fall && s_on_q && (s_cnt_q == 4'h8) && !s_ack_q;
	wire s_match = ten_s ? (s_byte_q ? (s_pre_q && low_hit) : pre_hit) : hit7;

	// Status word and read mux.
	assign sta_w = {6'h00, busy_q, ev_q[EV_TC], ev_q[EV_ND], st_q != M_IDLE,
		ev_q[EV_AL], ev_q[EV_NA], ev_q[EV_RX], ev_q[EV_TX], 2'h0};
	assign rd_w = (req_i.addr == OFF_MCTL) ? mctl_q
		: (req_i.addr == OFF_MSTA) ? sta_w
		: is_id ? {8'h00, id_q[id_ix]}
		: (req_i.addr == OFF_TLO) ? {8'h00, tlo_q}
		: (req_i.addr == OFF_THI) ? {8'h00, thi_q}
		: (req_i.addr == OFF_SCTL) ? {14'h0000, sctl_q}
		: (req_i.addr == OFF_TXD) ? {8'h00, txd_q}
		: (req_i.addr == OFF_RXD) ? {8'h00, rxd_q}
		: (req_i.addr == OFF_SSTA) ? {14'h0000, s_pre_q, s_addr_q}
		: 16'h0000;

	// Interrupt enables lined up with the event vector.
	wire [5:0] en_w = {mctl_q.stop_done_irq_enable, mctl_q.nack_irq_enable,
		mctl_q.nack_irq_enable, mctl_q.arb_lost_irq_enable,
		mctl_q.rx_data_irq_enable, mctl_q.tx_byte_irq_enable};

	assign rdata_o = rdata_q;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_o = scl_oe_q;
	assign sda_oe_o = sda_oe_q;
	assign irq_o = irq_q;

	// Master bit engine.
	always_comb begin
		st_d = st_q;
		bit_d = bit_q;
		ph_d = ph_q;
		sh_d = sh_q;
		rd_d = rd_q;
		rx_d = rxd_q;
		ev_set = 6'h00;
		unique case (st_q)
			M_IDLE: begin
				if (go_w) begin
					st_d = M_START;
					sh_d = tlo_q;
					ph_d = 2'h0;
					bit_d = 4'h0;
					rd_d = 1'b0;
				end
			end
			M_START: begin
				if (tick) st_d = M_LOW;
			end
			M_LOW: begin
				if (tick) st_d = M_HIGH;
			end
			M_HIGH: begin
				if (tick && arb_w) begin
					st_d = M_IDLE;
					ev_set[EV_AL] = 1'b1;
				end else if (tick && (bit_q < 4'h8)) begin
					bit_d = bit_q + 4'h1;
					sh_d = {sh_q[6:0], sda_l};
					st_d = M_LOW;
				end else if (tick) begin
					bit_d = 4'h0;
					st_d = M_STOP_A;
					if (rd_q) begin
						ev_set[EV_RX] = 1'b1;
						rx_d = sh_q;
					end else if (sda_l) begin
						ev_set[EV_ND] = ph_q == 2'h2;
						ev_set[EV_NA] = ph_q != 2'h2;
					end else begin
						ev_set[EV_TX] = 1'b1;
						if (ph_q == 2'h0 && ten_m) begin
							ph_d = 2'h1;
							sh_d = thi_q;
							st_d = M_LOW;
						end else if (ph_q != 2'h2) begin
							ph_d = 2'h2;
							rd_d = tlo_q[0];
							sh_d = txd_q;
							st_d = M_LOW;
						end
					end
				end
			end
			M_STOP_A: begin
				if (tick) st_d = M_STOP_B;
			end
			M_STOP_B: begin
				if (tick) st_d = M_STOP_C;
			end
			M_STOP_C: begin
				if (tick) st_d = M_IDLE;
			end
		endcase
		if (!men) st_d = M_IDLE;
		if (stop_w && men) ev_set[EV_TC] = 1'b1;
	end

	always_ff @(posedge clock_i) begin
		scl_s1 <= scl_i;
		scl_s2 <= scl_s1;
		sda_s1 <= sda_i;
		sda_s2 <= sda_s1;
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mctl_q <= MCTL_RST;
			tlo_q <= BYTE_RST;
			thi_q <= BYTE_RST;
			txd_q <= BYTE_RST;
			sctl_q <= SCTL_RST;
			for (int i = 0; i < 4; i++) id_q[i] <= BYTE_RST;
		end else begin
			if (wr_mctl) mctl_q <= req_i.wdata & MCTL_WMASK;
			if (wr_tlo) tlo_q <= req_i.wdata[7:0];
			if (wr_thi) thi_q <= req_i.wdata[7:0];
			if (wr_txd) txd_q <= req_i.wdata[7:0];
			if (wr_sctl) sctl_q <= req_i.wdata[1:0];
			if (req_i.we && is_id) id_q[id_ix] <= req_i.wdata[7:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rdata_q <= 16'h0000;
			ev_q <= 6'h00;
			irq_q <= 1'b0;
			txv_q <= 1'b0;
			rxd_q <= BYTE_RST;
		end else begin
			rdata_q <= req_i.re ? rd_w : 16'h0000;
			ev_q <= (rd_sta ? 6'h00 : ev_q) | ev_set;
			irq_q <= |(ev_q & en_w);
			txv_q <= wr_txd || (txv_q && !go_w);
			rxd_q <= rx_d;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			st_q <= M_IDLE;
			cnt_q <= '0;
			bit_q <= 4'h0;
			ph_q <= 2'h0;
			sh_q <= BYTE_RST;
			rd_q <= 1'b0;
		end else begin
			st_q <= st_d;
			bit_q <= bit_d;
			ph_q <= ph_d;
			sh_q <= sh_d;
			rd_q <= rd_d;
			if (st_d != st_q || tick || st_q == M_IDLE) cnt_q <= '0;
			else if (st_q != M_HIGH || scl_l) cnt_q <= cnt_q + CW'(1);
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			busy_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			scl_p_q <= scl_l;
			sda_p_q <= sda_l;
			busy_q <= start_w || (busy_q && !stop_w);
			scl_oe_q <= mscl_d;
			sda_oe_q <= msda_w || s_ack_q;
		end
	end

	// Slave address receiver.
	always_ff @(posedge clock_i) begin
		if (rst_i || !sen || stop_w) begin
			s_on_q <= 1'b0;
			s_cnt_q <= 4'h0;
			s_sh_q <= BYTE_RST;
			s_byte_q <= 1'b0;
			s_ack_q <= 1'b0;
			s_addr_q <= 1'b0;
			s_pre_q <= 1'b0;
		end else if (start_w) begin
			s_on_q <= 1'b1;
			s_cnt_q <= 4'h0;
			s_byte_q <= 1'b0;
			s_ack_q <= 1'b0;
			s_addr_q <= 1'b0;
			s_pre_q <= 1'b0;
		end else if (scl_fall && s_ack_q) begin
			s_ack_q <= 1'b0;
			s_cnt_q <= 4'h0;
			s_byte_q <= 1'b1;
			s_on_q <= !s_addr_q;
		end else if (s_cmp) begin
			s_ack_q <= s_match;
			s_on_q <= s_match;
			s_addr_q <= s_match && (!ten_s || s_byte_q);
			s_pre_q <= ten_s && !s_byte_q && s_match;
		end else if (scl_rise && s_on_q && s_cnt_q < 4'h8) begin
			s_sh_q <= {s_sh_q[6:0], sda_l};
			s_cnt_q <= s_cnt_q + 4'h1;
		end
	end

	// Checks.
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	sequence quiet_s;
		(mctl_q[8:4] == 5'h00) [*2];
	endsequence

	sequence arb_loss_s;
		(st_q == M_HIGH) && tick && arb_w && men;
	endsequence

	AST_RESET_ZERO: assert property ($fell(rst_i) |-> mctl_q == MCTL_RST && sta_w == 16'h0000)
		else $error("control or status not zero after reset");
	AST_IRQ_QUIET: assert property (quiet_s |-> !irq_o)
		else $error("interrupt raised with all enables clear");
	AST_RX_IRQ: assert property (ev_q[EV_RX] && mctl_q.rx_data_irq_enable |=> irq_o)
		else $error("enabled receive event gave no interrupt");
	AST_STOP_EV: assert property (stop_w && men |=> ev_q[EV_TC])
		else $error("stop not recorded as completion");
	AST_ARB_LOST: assert property (arb_loss_s |=> st_q == M_IDLE && ev_q[EV_AL])
		else $error("arbitration loss not handled");
	AST_BACKOFF: assert property (st_q == M_IDLE && busy_q && !mctl_q.backoff_disable
		|=> st_q == M_IDLE)
		else $error("master started on a busy bus");
	AST_NO_BACKOFF: assert property (st_q == M_IDLE && txv_q && men && mctl_q.backoff_disable
		|=> st_q == M_START)
		else $error("master held off despite back-off disable");
	AST_MASTER_OFF: assert property (!men |=> st_q == M_IDLE ##1 !scl_oe_o)
		else $error("master active while disabled");
	AST_SLAVE_MATCH: assert property (s_cmp && sen && !ten_s && hit7 |=> s_addr_q && s_ack_q)
		else $error("matching identifier not acknowledged");
	AST_LSB_IGNORED: assert property (s_cmp && sen && !ten_s
		&& (s_sh_q[7:1] == id_q[0][7:1]) |=> s_addr_q)
		else $error("direction bit affected matching");
	AST_ONE_ROLE: assert property (men |-> !s_on_q && !s_ack_q)
		else $error("slave active while master enabled");

endmodule : i2c_addr_master

// *** include/i2c_ctl_pkg.sv ***
// Constants, register map and carrier types for the two-wire address and master block.
// Assumes a 50 MHz system clock and one block instance per package user.
package i2c_ctl_pkg;

	// Register byte addresses.
	localparam logic [31:0] OFF_MCTL = 32'hffff0880;
	localparam logic [31:0] OFF_MSTA = 32'hffff0884;
	localparam logic [31:0] OFF_ID0 = 32'hffff0888;
	localparam logic [31:0] OFF_TLO = 32'hffff0898;
	localparam logic [31:0] OFF_THI = 32'hffff089c;
	localparam logic [31:0] OFF_SCTL = 32'hffff08a0;
	localparam logic [31:0] OFF_TXD = 32'hffff08a4;
	localparam logic [31:0] OFF_RXD = 32'hffff08a8;
	localparam logic [31:0] OFF_SSTA = 32'hffff08ac;
	localparam logic [31:0] ID_SPAN = 32'h00000010;

	// Reset values and writable masks.
	localparam logic [15:0] MCTL_RST = 16'h0000;
	localparam logic [15:0] MCTL_WMASK = 16'h01f7;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [1:0] SCTL_RST = 2'h0;

	// Slave control field positions.
	localparam int SCTL_EN = 0;
	localparam int SCTL_TEN = 1;

	// Sticky event positions inside the event vector.
	localparam int EV_TX = 0;
	localparam int EV_RX = 1;
	localparam int EV_AL = 2;
	localparam int EV_NA = 3;
	localparam int EV_ND = 4;
	localparam int EV_TC = 5;

	// Prefix that marks a ten-bit address byte.
	localparam logic [4:0] TEN_PREFIX = 5'h1e;

	// Bus timing: half of one 100 kHz bit period.
	localparam int CLK_NS = 20;
	localparam int HALF_NS = 5000;
	localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;

	typedef struct packed {
		logic [6:0] rsvd_hi;
		logic stop_done_irq_enable;
		logic nack_irq_enable;
		logic arb_lost_irq_enable;
		logic tx_byte_irq_enable;
		logic rx_data_irq_enable;
		logic rsvd3;
		logic internal_loopback_enable;
		logic backoff_disable;
		logic master_enable;
	} mctl_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] wdata;
		logic we;
		logic re;
	} reg_req_t;

	typedef enum logic [2:0] {
		M_IDLE = 3'h0,
		M_START = 3'h1,
		M_LOW = 3'h2,
		M_HIGH = 3'h3,
		M_STOP_A = 3'h4,
		M_STOP_B = 3'h5,
		M_STOP_C = 3'h6
	} mst_t;

endpackage : i2c_ctl_pkg

// *** tb/bus_slave_model.sv ***
// Behavioural slave on the two-wire bus that acknowledges one seven-bit address.
// Assumes the bench resolves the wired-AND lines with pull-ups.
`timescale 1ns/10ps

module bus_slave_model (
	// Resolved bus lines.
	input wire logic scl_i,
	input wire logic sda_i,
	// Address to answer and what was seen.
	input wire logic [6:0] addr_i,
	output logic pull_o,
	output logic [7:0] first_o,
	output logic [7:0] last_o,
	output logic [3:0] count_o
);
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	logic [3:0] bit_n = 4'h0;
	logic [7:0] shift = 8'h00;

	initial begin
		pull_o = 1'b0;
		first_o = 8'h00;
		last_o = 8'h00;
		count_o = 4'h0;
	end

	// The model never holds the clock low, so it keeps pace with the master.
	always @(scl_i or sda_i) begin
		if (scl_i === 1'b1 && scl_q && sda_q && sda_i === 1'b0) begin
			bit_n = 4'h0;
			count_o = 4'h0;
		end else if (scl_i === 1'b1 && scl_q === 1'b0) begin
			if (bit_n < 4'h8) begin
				shift = {shift[6:0], sda_i};
				bit_n++;
				if (bit_n == 4'h8) begin
					if (count_o == 4'h0) first_o = shift;
					else last_o = shift;
					count_o++;
				end
			end else begin
				bit_n = 4'h0;
			end
		end else if (scl_i === 1'b0 && scl_q === 1'b1) begin
			// A mismatched address is left to the pull-up, which reads as no acknowledge.
			pull_o = (bit_n == 4'h8) && (first_o[7:1] == addr_i);
		end
		scl_q = scl_i;
		sda_q = sda_i;
	end
endmodule : bus_slave_model

// *** tb/testbench.sv ***
// Self-checking bench for the two-wire address and master block.
// Assumes the slave model on pulled-up lines and a 50 MHz clock.
`timescale 1ns/10ps

module testbench;
	import i2c_ctl_pkg::*;

	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	reg_req_t req_i = '0;
	logic [15:0] rdata_o;
	logic scl_o;
	logic scl_oe_o;
	logic sda_o;
	logic sda_oe_o;
	logic irq_o;
	logic pull;
	logic [7:0] first_byte;
	logic [7:0] last_byte;
	logic [3:0] byte_count;
	logic scl_w;
	logic sda_w;
	logic seen_drive = 1'b0;
	int fail_count = 0;
	int num_checks = 0;

	assign scl_w = ~scl_oe_o;
	assign sda_w = ~(sda_oe_o | pull);

	always #10 clock_i = ~clock_i;
	always @(posedge clock_i) if (scl_oe_o === 1'b1) seen_drive <= 1'b1;

	i2c_addr_master #(.HALF_CYCLES(4)) i_i2c_addr_master (.clock_i(clock_i), .rst_i(rst_i),
		.req_i(req_i), .rdata_o(rdata_o), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
	bus_slave_model i_bus_slave_model (.scl_i(scl_w), .sda_i(sda_w), .addr_i(7'h2d),
		.pull_o(pull), .first_o(first_byte), .last_o(last_byte), .count_o(byte_count));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge clock_i);
		req_i.addr <= a;
		req_i.wdata <= d;
		req_i.we <= 1'b1;
		@(posedge clock_i);
		req_i.we <= 1'b0;
	endtask : wr

	task automatic rc(input string what, input logic [31:0] a, input logic [15:0] m,
		input logic [15:0] exp);
		@(posedge clock_i);
		req_i.addr <= a;
		req_i.re <= 1'b1;
		@(posedge clock_i);
		req_i.re <= 1'b0;
		#1 chk(what, exp, rdata_o & m);
	endtask : rc

	task automatic test_regs;
		rc("control reset", OFF_MCTL, 16'hffff, 16'h0000);
		rc("status reset", OFF_MSTA, 16'hffff, 16'h0000);
		wr(OFF_MSTA, 16'hffff);
		rc("status read only", OFF_MSTA, 16'hffff, 16'h0000);
		wr(OFF_MCTL, 16'hffff);
		rc("control reserved", OFF_MCTL, 16'hffff, 16'h01f7);
		wr(OFF_MCTL, 16'h0000);
		rc("control cleared", OFF_MCTL, 16'hffff, 16'h0000);
		wr(OFF_ID0, 16'h00a5);
		rc("identifier", OFF_ID0, 16'hffff, 16'h00a5);
		rc("unmapped", 32'hffff08b0, 16'hffff, 16'h0000);
	endtask : test_regs

	task automatic run_tx(input logic [15:0] ctl, input logic [7:0] tgt, input logic [15:0] m,
		input logic [15:0] sta, input logic [3:0] n);
		int i;
		wr(OFF_TLO, {8'h00, tgt});
		wr(OFF_MCTL, ctl);
		wr(OFF_TXD, 16'h00c3);
		for (i = 0; i < 3000 && irq_o !== 1'b1; i++) @(posedge clock_i);
		chk("irq raised", 16'h0001, {15'h0000, irq_o});
		chk("address byte", {8'h00, tgt}, {8'h00, first_byte});
		chk("byte count", {12'h000, n}, {12'h000, byte_count});
		rc("status events", OFF_MSTA, m, sta);
		repeat (2) @(posedge clock_i);
		chk("irq cleared", 16'h0000, {15'h0000, irq_o});
		wr(OFF_MCTL, 16'h0000);
	endtask : run_tx

	task automatic test_disabled;
		seen_drive = 1'b0;
		wr(OFF_TXD, 16'h0055);
		repeat (200) @(posedge clock_i);
		chk("no drive", 16'h0000, {15'h0000, seen_drive});
	endtask : test_disabled

	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : summarize

	initial begin
		#400000;
		fail_count++;
		summarize;
	end

	initial begin
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		test_regs;
		run_tx(16'h0101, 8'h5a, 16'h01bc, 16'h0104, 4'h2);
		chk("data byte", 16'h00c3, {8'h00, last_byte});
		run_tx(16'h0081, 8'h44, 16'h01b8, 16'h0010, 4'h1);
		test_disabled;
		summarize;
	end
endmodule : testbench
